/* File: hdl/divide_and_float_unpack.sv */
// Iterative divider with sign correction and floating-point unpack
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "divide_and_float_unpack_map.svh"

module divide_and_float_unpack #(
    parameter int WORD_W = `DFU_WORD_W
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [`DFU_ADDR_W-1:0] regAddr,
    input wire logic [WORD_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [WORD_W-1:0] regRdata,
    output logic busy,
    output logic divideFault,
    output logic floatHandoff,
    output logic opDone
);

    ////////////////////////////////////////////////////////////////////
    // Datapath and sequencing state

    divide_and_float_unpack_pkg::state_t state;
    divide_and_float_unpack_pkg::state_t next_state;
    divide_and_float_unpack_pkg::cmd_t cmd;
    divide_and_float_unpack_pkg::cmd_t next_cmd;

    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] next_acc;
    logic [WORD_W-1:0] quo;
    logic [WORD_W-1:0] next_quo;
    logic [WORD_W-1:0] divisor;
    logic [WORD_W-1:0] next_divisor;
    logic [`DFU_CNT_W-1:0] ctlQuantity;
    logic [`DFU_CNT_W-1:0] next_ctlQuantity;
    logic [`DFU_CNT_W-1:0] stepCounter;
    logic [`DFU_CNT_W-1:0] next_stepCounter;
    logic [`DFU_EXP_W-1:0] expReg;
    logic [`DFU_EXP_W-1:0] next_expReg;
    logic quotientSignFlag;
    logic next_quotientSignFlag;
    logic dividendSignFlag;
    logic next_dividendSignFlag;
    logic divideFaultFlag;
    logic next_divideFaultFlag;
    logic floatPending;
    logic next_floatPending;
    logic doneFlag;
    logic next_doneFlag;
    logic [WORD_W-1:0] rdata;
    logic [WORD_W-1:0] next_rdata;

    logic [2*WORD_W-1:0] shifted;
    logic [WORD_W-1:0] partial;
    logic [WORD_W-1:0] opA;
    logic [WORD_W-1:0] opX;
    logic accGe;
    logic [`DFU_CMD_HI:`DFU_CMD_LO] cmdField;

    assign cmdField = regWdata[`DFU_CMD_HI:`DFU_CMD_LO];

    // Partial dividend moved left one place before the trial subtract
    assign shifted = {acc, quo} << 1;
    assign partial = shifted[2*WORD_W-1:WORD_W];

    // Unpack view: whole word complemented when negative
    assign opA = acc[`DFU_SIGN_BIT] ? ~acc : acc;
    assign opX = divisor[`DFU_SIGN_BIT] ? ~divisor : divisor;

    // Biased exponent lets a plain signed compare order float words
    assign accGe = $signed(acc) >= $signed(divisor);

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        next_state = state;
        next_cmd = cmd;
        next_acc = acc;
        next_quo = quo;
        next_divisor = divisor;
        next_ctlQuantity = ctlQuantity;
        next_stepCounter = stepCounter;
        next_expReg = expReg;
        next_quotientSignFlag = quotientSignFlag;
        next_dividendSignFlag = dividendSignFlag;
        next_divideFaultFlag = divideFaultFlag;
        next_floatPending = floatPending;
        next_doneFlag = 1'b0;
        next_rdata = '0;

        // Data and command register writes are taken only while idle so software
        // cannot corrupt a division in flight
        if (regWrite && state == divide_and_float_unpack_pkg::ST_IDLE) begin
            case (regAddr)
                `DFU_REG_ACC: begin
                    next_acc = regWdata;
                end
                `DFU_REG_QUO: begin
                    next_quo = regWdata;
                end
                `DFU_REG_DIVISOR: begin
                    next_divisor = regWdata;
                end
                `DFU_REG_COMMAND: begin
                    if (cmdField != 3'(divide_and_float_unpack_pkg::CMD_NONE)
                        && cmdField <= 3'(divide_and_float_unpack_pkg::CMD_UNPACK)) begin
                        next_cmd = divide_and_float_unpack_pkg::cmd_t'(cmdField);
                        next_floatPending = 1'b0;
                        next_state = divide_and_float_unpack_pkg::ST_INIT;
                    end
                end
                default: begin
                end
            endcase
        end

        // Fault clear may come at any time; a new fault below wins
        if (regWrite && regAddr == `DFU_REG_STATUS
            && regWdata[`DFU_CLR_FAULT]) begin
            next_divideFaultFlag = 1'b0;
        end

        case (state)
            divide_and_float_unpack_pkg::ST_IDLE: begin
            end
            divide_and_float_unpack_pkg::ST_INIT: begin
                if (cmd == divide_and_float_unpack_pkg::CMD_UNPACK) begin
                    // Coefficients to A and X, exponents to U and R
                    next_acc = '0;
                    next_acc[`DFU_FRAC_HI:0] = opA[`DFU_FRAC_HI:0];
                    next_divisor = '0;
                    next_divisor[`DFU_FRAC_HI:0] = opX[`DFU_FRAC_HI:0];
                    // Exponent passed as found: a negative-form zero
                    // only appears if an operand carried it
                    next_expReg = opA[`DFU_EXP_HI:`DFU_EXP_LO];
                    next_stepCounter = opX[`DFU_EXP_HI:`DFU_EXP_LO];
                    next_quotientSignFlag = acc[`DFU_SIGN_BIT]
                        ^ divisor[`DFU_SIGN_BIT];
                    next_dividendSignFlag = acc[`DFU_SIGN_BIT];
                    next_floatPending = 1'b1;
                    next_doneFlag = 1'b1;
                    next_state = divide_and_float_unpack_pkg::ST_IDLE;
                end else begin
                    if (cmd == divide_and_float_unpack_pkg::CMD_DIV_INT) begin
                        // Integer dividend arrives as QA
                        next_acc = quo;
                        next_quo = acc;
                        next_dividendSignFlag = quo[`DFU_SIGN_BIT];
                        if (quo[`DFU_SIGN_BIT]) begin
                            next_acc = ~quo;
                            next_quo = ~acc;
                        end
                    end else begin
                        next_dividendSignFlag = acc[`DFU_SIGN_BIT];
                        if (acc[`DFU_SIGN_BIT]) begin
                            next_acc = ~acc;
                            next_quo = ~quo;
                        end
                    end
                    next_quotientSignFlag = divisor[`DFU_SIGN_BIT]
                        ^ (cmd == divide_and_float_unpack_pkg::CMD_DIV_INT
                           ? quo[`DFU_SIGN_BIT] : acc[`DFU_SIGN_BIT]);
                    if (divisor[`DFU_SIGN_BIT]) begin
                        next_divisor = ~divisor;
                    end
                    next_state = divide_and_float_unpack_pkg::ST_LOADCQ;
                end
            end
            divide_and_float_unpack_pkg::ST_LOADCQ: begin
                next_ctlQuantity =
                    (cmd == divide_and_float_unpack_pkg::CMD_DIV_FLOAT)
                    ? `DFU_STEPS_FLOAT : `DFU_STEPS_FIXED;
                next_state = divide_and_float_unpack_pkg::ST_XFERCNT;
            end
            divide_and_float_unpack_pkg::ST_XFERCNT: begin
                next_stepCounter = ctlQuantity;
                next_state = divide_and_float_unpack_pkg::ST_STEP;
            end
            divide_and_float_unpack_pkg::ST_STEP: begin
                next_quo = shifted[WORD_W-1:0];
                if (partial >= divisor) begin
                    next_acc = partial - divisor;
                    next_quo[0] = 1'b1;
                end else begin
                    next_acc = partial;
                end
                next_stepCounter = stepCounter - `DFU_CNT_W'(1);
                if (stepCounter == `DFU_CNT_W'(1)) begin
                    next_state = divide_and_float_unpack_pkg::ST_FAULTCHK;
                end
            end
            divide_and_float_unpack_pkg::ST_FAULTCHK: begin
                // Quotient needing more than 47 bits lands in the sign
                if (quo[`DFU_SIGN_BIT]) begin
                    next_divideFaultFlag = 1'b1;
                end
                next_state = divide_and_float_unpack_pkg::ST_FINAL;
            end
            divide_and_float_unpack_pkg::ST_FINAL: begin
                if (quotientSignFlag) begin
                    next_quo = ~quo;
                end
                if (dividendSignFlag) begin
                    next_acc = ~acc;
                end
                next_state = divide_and_float_unpack_pkg::ST_PLACE;
            end
            divide_and_float_unpack_pkg::ST_PLACE: begin
                next_acc = quo;
                next_quo = acc;
                // Round and normalize live outside this block
                if (cmd == divide_and_float_unpack_pkg::CMD_DIV_FLOAT) begin
                    next_floatPending = 1'b1;
                end
                next_doneFlag = 1'b1;
                next_state = divide_and_float_unpack_pkg::ST_IDLE;
            end
            default: begin
                next_state = divide_and_float_unpack_pkg::ST_IDLE;
            end
        endcase

        if (regRead) begin
            case (regAddr)
                `DFU_REG_ACC: begin
                    next_rdata = acc;
                end
                `DFU_REG_QUO: begin
                    next_rdata = quo;
                end
                `DFU_REG_DIVISOR: begin
                    next_rdata = divisor;
                end
                `DFU_REG_COMMAND: begin
                    next_rdata[`DFU_CMD_HI:`DFU_CMD_LO] = 3'(cmd);
                end
                `DFU_REG_STATUS: begin
                    next_rdata[`DFU_ST_BUSY] =
                        state != divide_and_float_unpack_pkg::ST_IDLE;
                    next_rdata[`DFU_ST_FAULT] = divideFaultFlag;
                    next_rdata[`DFU_ST_QSIGN] = quotientSignFlag;
                    next_rdata[`DFU_ST_DSIGN] = dividendSignFlag;
                    next_rdata[`DFU_ST_FLOATPEND] = floatPending;
                    next_rdata[`DFU_ST_ACCGE] = accGe;
                end
                `DFU_REG_EXPONENTS: begin
                    next_rdata[`DFU_EXP_W-1:0] = expReg;
                    next_rdata[2*`DFU_EXP_W-1:`DFU_EXP_W] = stepCounter;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= divide_and_float_unpack_pkg::ST_IDLE;
            cmd <= divide_and_float_unpack_pkg::CMD_NONE;
            acc <= '0;
            quo <= '0;
            divisor <= '0;
            ctlQuantity <= '0;
            stepCounter <= '0;
            expReg <= `DFU_EXP_BIAS;
            quotientSignFlag <= 1'b0;
            dividendSignFlag <= 1'b0;
            divideFaultFlag <= 1'b0;
            floatPending <= 1'b0;
            doneFlag <= 1'b0;
            rdata <= '0;
        end else begin
            state <= next_state;
            cmd <= next_cmd;
            acc <= next_acc;
            quo <= next_quo;
            divisor <= next_divisor;
            ctlQuantity <= next_ctlQuantity;
            stepCounter <= next_stepCounter;
            expReg <= next_expReg;
            quotientSignFlag <= next_quotientSignFlag;
            dividendSignFlag <= next_dividendSignFlag;
            divideFaultFlag <= next_divideFaultFlag;
            floatPending <= next_floatPending;
            doneFlag <= next_doneFlag;
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs, each a flip-flop

    always_ff @(posedge mclk) begin
        if (srst) begin
            busy <= 1'b0;
            divideFault <= 1'b0;
            floatHandoff <= 1'b0;
        end else begin
            busy <= next_state != divide_and_float_unpack_pkg::ST_IDLE;
            divideFault <= next_divideFaultFlag;
            floatHandoff <= next_floatPending;
        end
    end

    assign regRdata = rdata;
    assign opDone = doneFlag;

endmodule : divide_and_float_unpack

/* File: hdl/divide_and_float_unpack_map.svh */
// Offsets, field positions, reset values and counts for the divide unit
`ifndef DIVIDE_AND_FLOAT_UNPACK_MAP_SVH
`define DIVIDE_AND_FLOAT_UNPACK_MAP_SVH

`define DFU_WORD_W 48
`define DFU_SIGN_BIT 47
`define DFU_EXP_HI 46
`define DFU_EXP_LO 36
`define DFU_FRAC_HI 35
`define DFU_EXP_W 11
`define DFU_EXP_BIAS 11'h400
`define DFU_CNT_W 11
`define DFU_STEPS_FIXED 11'h030
`define DFU_STEPS_FLOAT 11'h024

`define DFU_ADDR_W 4
`define DFU_REG_ACC 4'h0
`define DFU_REG_QUO 4'h1
`define DFU_REG_DIVISOR 4'h2
`define DFU_REG_COMMAND 4'h3
`define DFU_REG_STATUS 4'h4
`define DFU_REG_EXPONENTS 4'h5

`define DFU_CMD_LO 0
`define DFU_CMD_HI 2
`define DFU_ST_BUSY 0
`define DFU_ST_FAULT 1
`define DFU_ST_QSIGN 2
`define DFU_ST_DSIGN 3
`define DFU_ST_FLOATPEND 4
`define DFU_ST_ACCGE 5
`define DFU_ST_W 6
`define DFU_CLR_FAULT 1

`endif

/* File: hdl/divide_and_float_unpack_pkg.sv */
// Types shared by the divide and unpack unit
package divide_and_float_unpack_pkg;

    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_DIV_INT,
        CMD_DIV_FRAC,
        CMD_DIV_FLOAT,
        CMD_UNPACK
    } cmd_t;

    typedef enum {
        ST_IDLE,
        ST_INIT,
        ST_LOADCQ,
        ST_XFERCNT,
        ST_STEP,
        ST_FAULTCHK,
        ST_FINAL,
        ST_PLACE
    } state_t;

endpackage : divide_and_float_unpack_pkg

/* File: testbench/control_section_model.sv */
// Control section model: master of the register port
`timescale 1ns/1ps
`include "divide_and_float_unpack_map.svh"

module control_section_model (
    input wire logic mclk,
    input wire logic [`DFU_WORD_W-1:0] regRdata,
    output logic [`DFU_ADDR_W-1:0] regAddr,
    output logic [`DFU_WORD_W-1:0] regWdata,
    output logic regWrite,
    output logic regRead
);
    initial begin
        regAddr = 4'h0;
        regWdata = 48'h0;
        regWrite = 1'b0;
        regRead = 1'b0;
    end

    // Loads dividend and divisor, clears the fault
    task automatic wr(input logic [3:0] a, input logic [47:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
        // Stale data is not left on the bus
        regWdata <= ~d;
    endtask : wr

    // Status read senses the sticky fault
    task automatic rd(input logic [3:0] a, output logic [47:0] d);
        @(posedge mclk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(negedge mclk);
        d = regRdata;
    endtask : rd
endmodule : control_section_model

/* File: testbench/divide_and_float_unpack_assertions.sv */
// Checker for the divide and unpack unit ports
`timescale 1ns/1ps
`include "divide_and_float_unpack_map.svh"

module divide_and_float_unpack_assertions #(
    parameter int WORD_W = `DFU_WORD_W
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [`DFU_ADDR_W-1:0] regAddr,
    input wire logic [WORD_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [WORD_W-1:0] regRdata,
    input wire logic busy,
    input wire logic divideFault,
    input wire logic floatHandoff,
    input wire logic opDone
);
    logic [2:0] lastCmd;
    logic [2:0] next_lastCmd;
    int busyLen;
    int next_busyLen;
    logic start;
    logic clearReq;

    function automatic int spanFor(logic [2:0] c);
        if (c == 3'h4) return 1;
        // Init, load, transfer, N steps, fault check, final, place
        if (c == 3'h3) return int'(`DFU_STEPS_FLOAT) + 6;
        return int'(`DFU_STEPS_FIXED) + 6;
    endfunction : spanFor

    assign start = regWrite && regAddr == `DFU_REG_COMMAND && !busy
        && regWdata[2:0] >= 3'h1 && regWdata[2:0] <= 3'h4;
    assign clearReq = regWrite && regAddr == `DFU_REG_STATUS
        && regWdata[`DFU_CLR_FAULT];

    always_comb begin
        next_lastCmd = start ? regWdata[2:0] : lastCmd;
        next_busyLen = start ? 0 : busyLen + (busy ? 1 : 0);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            lastCmd <= 3'h0;
            busyLen <= 0;
        end else begin
            lastCmd <= next_lastCmd;
            busyLen <= next_busyLen;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);

    sequence launch;
        start;
    endsequence
    sequence finish;
        opDone && !busy;
    endsequence

    op_span_a: assert property (opDone |-> busyLen == spanFor(lastCmd))
        else $error("busy span wrong for command");
    launch_busy_a: assert property (launch |=> busy ##1 (busy || opDone))
        else $error("command did not start");
    done_bound_a: assert property (launch |-> ##[2:60] finish)
        else $error("operation did not finish");
    done_pulse_a: assert property (opDone |-> $past(busy) ##1 !opDone)
        else $error("done pulse malformed");
    fault_hold_a: assert property (divideFault && !clearReq |=> divideFault)
        else $error("fault flag dropped");
    fault_clear_a: assert property (clearReq && !busy |=> !divideFault)
        else $error("fault flag not cleared");
    fault_source_a: assert property ($rose(divideFault) |-> $past(busy))
        else $error("fault set outside operation");
    handoff_a: assert property (finish |->
        floatHandoff == (lastCmd == 3'h3 || lastCmd == 3'h4))
        else $error("handoff flag wrong at finish");
    rdata_quiet_a: assert property (!regRead |=> regRdata == '0)
        else $error("read data outside answer cycle");
endmodule : divide_and_float_unpack_assertions

bind divide_and_float_unpack divide_and_float_unpack_assertions #(
    .WORD_W(WORD_W)
) chk (.mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .busy(busy), .divideFault(divideFault), .floatHandoff(floatHandoff),
    .opDone(opDone));

/* File: testbench/tb_divide_and_float_unpack.sv */
// Self-checking bench for the divide and unpack unit
`timescale 1ns/1ps
`include "divide_and_float_unpack_map.svh"
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
    errors++; $display("unexpected at %0t: %h vs %h", $time, got, exp); end end

module tb_divide_and_float_unpack;
    localparam logic [47:0] ALL = 48'hFFFF_FFFF_FFFF;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] regAddr;
    logic [47:0] regWdata, regRdata;
    logic regWrite, regRead, busy, divideFault, floatHandoff, opDone;
    int errors = 0;
    int total_checks = 0;
    int busyCount = 0;
    int cycles = 0;

    always #10 mclk = ~mclk;

    divide_and_float_unpack DUT (.mclk(mclk), .srst(srst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .busy(busy), .divideFault(divideFault),
        .floatHandoff(floatHandoff), .opDone(opDone));
    control_section_model ctl (.mclk(mclk), .regRdata(regRdata),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
        .regRead(regRead));

    always @(negedge mclk) if (busy === 1'b1) busyCount++;

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("errors %0d checks %0d", errors, total_checks);
        if (errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [3:0] a, input logic [47:0] m, e);
        logic [47:0] d;
        ctl.rd(a, d);
        `CHECK(d & m, e)
    endtask : chk

    task automatic start_op(input logic [2:0] c, input logic [47:0] a, q, x,
        input int n);
        int i;
        ctl.wr(`DFU_REG_ACC, a);
        ctl.wr(`DFU_REG_QUO, q);
        ctl.wr(`DFU_REG_DIVISOR, x);
        busyCount = 0;
        ctl.wr(`DFU_REG_COMMAND, {45'h0, c});
        // Must be ignored mid-operation, results prove it
        if (n > 1) ctl.wr(`DFU_REG_ACC, 48'h0BAD_0BAD_0BAD);
        for (i = 0; i < 200 && opDone !== 1'b1; i++) @(negedge mclk);
        `CHECK(busyCount, n)
    endtask : start_op

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        chk(`DFU_REG_ACC, ALL, 48'h0);
        chk(`DFU_REG_STATUS, ALL, 48'h20);
        chk(`DFU_REG_EXPONENTS, ALL, 48'h400);
        chk(4'h6, ALL, 48'h0);
        start_op(3'h2, 48'h1, 48'h0, 48'h3, 54);
        chk(`DFU_REG_ACC, ALL, 48'h5555_5555_5555);
        chk(`DFU_REG_QUO, ALL, 48'h1);
        chk(`DFU_REG_STATUS, ALL, 48'h20);
        start_op(3'h2, ~48'h1, ~48'h0, 48'h3, 54);
        chk(`DFU_REG_ACC, ALL, 48'hAAAA_AAAA_AAAA);
        chk(`DFU_REG_QUO, ALL, 48'hFFFF_FFFF_FFFE);
        chk(`DFU_REG_STATUS, ALL, 48'h0C);
        start_op(3'h2, 48'h1, 48'h0, ~48'h3, 54);
        chk(`DFU_REG_ACC, ALL, 48'hAAAA_AAAA_AAAA);
        chk(`DFU_REG_QUO, ALL, 48'h1);
        chk(`DFU_REG_STATUS, ALL, 48'h04);
        start_op(3'h1, 48'h0, 48'h1, 48'h3, 54);
        chk(`DFU_REG_ACC, ALL, 48'h5555_5555_5555);
        chk(`DFU_REG_QUO, ALL, 48'h1);
        start_op(3'h3, 48'h1, 48'h0, 48'h3, 42);
        chk(`DFU_REG_ACC, ALL, 48'h0005_5555_5555);
        chk(`DFU_REG_STATUS, ALL, 48'h30);
        `CHECK(floatHandoff, 1'b1)
        start_op(3'h2, 48'h3, 48'h0, 48'h3, 54);
        `CHECK(divideFault, 1'b1)
        `CHECK(floatHandoff, 1'b0)
        chk(`DFU_REG_STATUS, 48'h1F, 48'h02);
        start_op(3'h2, 48'h1, 48'h0, 48'h3, 54);
        `CHECK(divideFault, 1'b1)
        ctl.wr(`DFU_REG_STATUS, 48'h2);
        // Flag updates on the write edge; look once it has settled
        @(negedge mclk);
        `CHECK(divideFault, 1'b0)
        start_op(3'h4, 48'hBF53_FFFF_FFFF, 48'h0, 48'h4008_0000_0000, 1);
        chk(`DFU_REG_ACC, ALL, 48'hC_0000_0000);
        chk(`DFU_REG_DIVISOR, ALL, 48'h8_0000_0000);
        chk(`DFU_REG_EXPONENTS, ALL, 48'h20040A);
        chk(`DFU_REG_STATUS, ALL, 48'h3C);
        `CHECK(floatHandoff, 1'b1)
        ctl.wr(`DFU_REG_ACC, 48'h4038_0000_0000);
        ctl.wr(`DFU_REG_DIVISOR, 48'h3FD8_0000_0000);
        chk(`DFU_REG_STATUS, 48'h20, 48'h20);
        ctl.wr(`DFU_REG_ACC, 48'hBFC7_FFFF_FFFF);
        ctl.wr(`DFU_REG_DIVISOR, 48'hC027_FFFF_FFFF);
        chk(`DFU_REG_STATUS, 48'h20, 48'h00);
        end_sim();
    end
endmodule : tb_divide_and_float_unpack
